// File: verilog/cxpi_role_switch_arbitration_txd_guard.sv
// Mode, arbitration, clock watch and txd guard logic of a CXPI transceiver
`default_nettype none
`timescale 1ns/1ps
module cxpi_role_switch_arbitration_txd_guard #(
    parameter int CLK_LOSS_CYC   = cxpi_guard_pkg::CLK_LOSS_CYC,
    parameter int WAKE_PULSE_CYC = cxpi_guard_pkg::WAKE_PULSE_CYC,
    parameter int MODE_CHG_CYC   = cxpi_guard_pkg::MODE_CHG_CYC,
    parameter int IFS_BITS       = cxpi_guard_pkg::IFS_BITS,
    parameter int WAKE_RETRIES   = cxpi_guard_pkg::WAKE_RETRIES
) (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   nrst_i,
    // Host side pins
    input  wire logic                   txd_i,
    input  wire logic                   sleep_request_n_i,
    input  wire logic                   role_select_i,
    input  wire logic                   clk_pin_i,
    output logic                        clk_pin_o,
    output logic                        clk_pin_oe_o,
    output logic                        rxd_o,
    output logic                        rxd_oe_o,
    // Bus side
    input  wire logic                   bus_rx_i,
    output logic                        bus_dom_o,
    output logic                        bus_en_o,
    // Supervisor flags
    input  wire logic                   lvr_i,
    input  wire logic                   tsd_i,
    input  wire logic                   wake_evt_i,
    // State
    output cxpi_guard_pkg::mode_t       mode_o,
    output cxpi_guard_pkg::status_t     status_o
);
    localparam int CW = cxpi_guard_pkg::CNT_W;

    cxpi_guard_pkg::pin_in_t raw, lvl, rise, fall;
    cxpi_guard_pkg::mode_t   mode, next_mode;

    logic          slave;
    logic [5:0]    pwr_cnt;
    logic [CW-1:0] mode_cnt;
    logic [CW-1:0] clk_cnt;
    logic [CW-1:0] wake_cnt;
    logic [CW-1:0] ifs_cnt;
    logic [3:0]    retry_cnt;
    logic          bus_error;
    logic          arb_lost;
    logic          tx_en;
    logic          seen_high;
    logic          no_clk_wake;
    logic          secondary;
    logic          wake_retx;
    logic          pending_retx;
    logic          rearm;
    logic          use_clk_in;
    logic          sample;
    logic          tsd_eff;
    logic          wake_start;

    assign raw = '{txd: txd_i, sleep_request_n: sleep_request_n_i,
        role_select: role_select_i, clk_pin: clk_pin_i, bus_rx: bus_rx_i,
        lvr: lvr_i, tsd: tsd_i, wake_evt: wake_evt_i};

    pin_sync #(
        .WIDTH     ($bits(cxpi_guard_pkg::pin_in_t)),
        .RESET_VAL (cxpi_guard_pkg::PIN_RESET)
    ) u_sync (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i (raw),
        .level_o (lvl),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    // Thermal protection inactive in sleep
    assign tsd_eff    = lvl.tsd && (mode != cxpi_guard_pkg::MODE_SLEEP);
    // Bit clock from host pin for master or stand-in master
    assign use_clk_in = !slave || secondary;
    assign sample     = use_clk_in ? rise.clk_pin : rise.bus_rx;
    // Guard rearm: reset, thermal end, normal or sleep entry
    assign rearm = (mode != next_mode &&
                    (next_mode == cxpi_guard_pkg::MODE_NORMAL ||
                     next_mode == cxpi_guard_pkg::MODE_SLEEP)) ||
                   (mode == cxpi_guard_pkg::MODE_PWRUP) || fall.tsd;
    // Wakeup event, guarded txd low or pending resend
    assign wake_start = lvl.wake_evt || (tx_en && !lvl.txd) || pending_retx;

    // Mode transitions
    always_comb begin
        next_mode = mode;
        case (mode)
            cxpi_guard_pkg::MODE_LVR:
                next_mode = cxpi_guard_pkg::MODE_PWRUP;
            cxpi_guard_pkg::MODE_PWRUP:
                if (rise.clk_pin &&
                    pwr_cnt == 6'(cxpi_guard_pkg::PWRUP_CLK_PERIODS - 1)) begin
                    next_mode = lvl.sleep_request_n ?
                        cxpi_guard_pkg::MODE_STANDBY :
                        cxpi_guard_pkg::MODE_SLEEP;
                end
            cxpi_guard_pkg::MODE_STANDBY:
                if (!lvl.sleep_request_n) begin
                    next_mode = cxpi_guard_pkg::MODE_SLEEP;
                end else if (mode_cnt >= CW'(MODE_CHG_CYC - 1)) begin
                    next_mode = cxpi_guard_pkg::MODE_NORMAL;
                end
            cxpi_guard_pkg::MODE_NORMAL:
                if (!lvl.sleep_request_n) begin
                    next_mode = cxpi_guard_pkg::MODE_SLEEP;
                end
            cxpi_guard_pkg::MODE_SLEEP:
                if (lvl.sleep_request_n) begin
                    next_mode = cxpi_guard_pkg::MODE_STANDBY;
                end else if (wake_start) begin
                    next_mode = cxpi_guard_pkg::MODE_WAKE;
                end
            cxpi_guard_pkg::MODE_WAKE:
                if (wake_cnt >= CW'(WAKE_PULSE_CYC - 1)) begin
                    next_mode = lvl.sleep_request_n ?
                        cxpi_guard_pkg::MODE_STANDBY :
                        cxpi_guard_pkg::MODE_SLEEP;
                end
            default:
                next_mode = cxpi_guard_pkg::MODE_LVR;
        endcase
    end

    // Mode register, forced by low-voltage reset
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode <= cxpi_guard_pkg::MODE_LVR;
        end else if (lvl.lvr) begin
            mode <= cxpi_guard_pkg::MODE_LVR;
        end else begin
            mode <= next_mode;
        end
    end

    // Mode timers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_cnt  <= '0;
            mode_cnt <= '0;
            wake_cnt <= '0;
        end else begin
            if (mode != cxpi_guard_pkg::MODE_PWRUP) begin
                pwr_cnt <= '0;
            end else if (rise.clk_pin) begin
                pwr_cnt <= pwr_cnt + 6'h01;
            end
            mode_cnt <= (mode == cxpi_guard_pkg::MODE_STANDBY) ?
                        mode_cnt + 1'b1 : '0;
            wake_cnt <= (mode == cxpi_guard_pkg::MODE_WAKE) ?
                        wake_cnt + 1'b1 : '0;
        end
    end

    // Role latched only in sleep
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slave <= 1'b0;
        end else if (mode == cxpi_guard_pkg::MODE_SLEEP) begin
            slave <= lvl.role_select;
        end
    end

    // Clock watchdog on bus falling edges
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_cnt   <= '0;
            bus_error <= 1'b0;
        end else if (mode == cxpi_guard_pkg::MODE_LVR ||
                     mode == cxpi_guard_pkg::MODE_WAKE ||
                     fall.bus_rx) begin
            clk_cnt   <= '0;
            bus_error <= 1'b0;
        end else if (clk_cnt >= CW'(CLK_LOSS_CYC - 1)) begin
            bus_error <= 1'b1;
        end else begin
            clk_cnt <= clk_cnt + 1'b1;
        end
    end

    // Resend wakeup while clock stays missing
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            retry_cnt    <= '0;
            pending_retx <= 1'b0;
            wake_retx    <= 1'b0;
        end else begin
            wake_retx <= 1'b0;
            if (mode == cxpi_guard_pkg::MODE_WAKE) begin
                pending_retx <= 1'b0;
            end else if (fall.bus_rx || mode == cxpi_guard_pkg::MODE_LVR) begin
                retry_cnt    <= '0;
                pending_retx <= 1'b0;
            end else if (mode == cxpi_guard_pkg::MODE_SLEEP &&
                         clk_cnt == CW'(CLK_LOSS_CYC - 2) &&
                         retry_cnt < 4'(WAKE_RETRIES) &&
                         !pending_retx) begin
                retry_cnt    <= retry_cnt + 4'h1;
                pending_retx <= 1'b1;
                wake_retx    <= 1'b1;
            end
        end
    end

    // Stand-in clock master after clock absent through wakeup
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            no_clk_wake <= 1'b0;
            secondary   <= 1'b0;
        end else if (mode == cxpi_guard_pkg::MODE_LVR) begin
            no_clk_wake <= 1'b0;
            secondary   <= 1'b0;
        end else begin
            if (mode inside {cxpi_guard_pkg::MODE_SLEEP,
                             cxpi_guard_pkg::MODE_WAKE}) begin
                no_clk_wake <= 1'b1;
                secondary   <= 1'b0;
            end else if (fall.bus_rx && !secondary) begin
                no_clk_wake <= 1'b0;
            end
            if (mode == cxpi_guard_pkg::MODE_NORMAL && slave &&
                no_clk_wake && bus_error) begin
                secondary <= 1'b1;
            end
        end
    end

    // Guard: high seen then falling edge; rearm wins
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_en     <= 1'b0;
            seen_high <= 1'b0;
        end else if (rearm || mode == cxpi_guard_pkg::MODE_LVR || tsd_eff) begin
            // Clear guard and high flag on each rearm event
            tx_en     <= 1'b0;
            seen_high <= 1'b0;
        end else begin
            if (lvl.txd) begin
                seen_high <= 1'b1;
            end
            // Valid from a falling edge after high
            if (fall.txd && seen_high) begin
                tx_en <= 1'b1;
            end
        end
    end

    // Bit compare at each sample; from first bit
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arb_lost <= 1'b0;
            ifs_cnt  <= '0;
        end else if (mode != cxpi_guard_pkg::MODE_NORMAL) begin
            arb_lost <= 1'b0;
            ifs_cnt  <= '0;
        end else if (sample) begin
            if (!lvl.bus_rx) begin
                ifs_cnt <= '0;
            end else if (ifs_cnt >= CW'(IFS_BITS - 1)) begin
                arb_lost <= 1'b0;
                ifs_cnt  <= '0;
            end else begin
                ifs_cnt <= ifs_cnt + 1'b1;
            end
            // Per-bit decision; loss wins over space clear
            if (tx_en && !arb_lost && lvl.txd != lvl.bus_rx) begin
                arb_lost <= 1'b1;
            end
        end
    end

    // Output pins; dominant through the guard in normal mode, or during the wake pulse
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_dom_o    <= 1'b0;
            bus_en_o     <= 1'b0;
            rxd_o        <= 1'b1;
            rxd_oe_o     <= 1'b0;
            clk_pin_o    <= 1'b1;
            clk_pin_oe_o <= 1'b0;
        end else begin
            bus_en_o <= mode != cxpi_guard_pkg::MODE_LVR &&
                        mode != cxpi_guard_pkg::MODE_PWRUP && !tsd_eff;
            bus_dom_o <= !tsd_eff &&
                ((mode == cxpi_guard_pkg::MODE_NORMAL && tx_en &&
                  !arb_lost && !lvl.txd) ||
                 mode == cxpi_guard_pkg::MODE_WAKE);
            // Receiver follows bus regardless of guard
            rxd_o        <= lvl.bus_rx;
            rxd_oe_o     <= mode != cxpi_guard_pkg::MODE_LVR &&
                            mode != cxpi_guard_pkg::MODE_STANDBY;
            clk_pin_o    <= lvl.bus_rx;
            clk_pin_oe_o <= slave && !secondary &&
                            mode == cxpi_guard_pkg::MODE_NORMAL;
        end
    end

    assign mode_o   = mode;
    assign status_o = '{bus_error: bus_error, arb_lost: arb_lost,
        tx_enabled: tx_en, secondary_master: secondary, wake_retx: wake_retx};
endmodule // cxpi_role_switch_arbitration_txd_guard
`default_nettype wire

// File: verilog/cxpi_guard_pkg.sv
// Shared constants and carrier types for the role switch and txd guard block
`default_nettype none
package cxpi_guard_pkg;
    // Clock rate of the block
    localparam int CLK_MHZ          = 40;
    // Link clock periods counted after low-voltage reset release
    localparam int PWRUP_CLK_PERIODS = 33;
    // Standby dwell before normal mode, in microseconds
    localparam int MODE_CHG_US      = 10;
    localparam int MODE_CHG_CYC     = MODE_CHG_US * CLK_MHZ;
    // Longest gap between clock edges before the clock counts as missing
    localparam int CLK_LOSS_US      = 1000;
    localparam int CLK_LOSS_CYC     = CLK_LOSS_US * CLK_MHZ;
    // Width of a wakeup pulse driven by the block
    localparam int WAKE_PULSE_US    = 402;
    localparam int WAKE_PULSE_CYC   = WAKE_PULSE_US * CLK_MHZ;
    // Recessive bits that make up an inter-frame space
    localparam int IFS_BITS         = 10;
    // Wakeup pulses resent when no clock follows
    localparam int WAKE_RETRIES     = 2;
    // Counter width for the standby, wake, clock-loss and space timers
    localparam int CNT_W            = 16;

    // Mode states, Gray coded along power-up, standby, normal, sleep, wake
    typedef enum logic [2:0] {
        MODE_LVR     = 3'h0,
        MODE_PWRUP   = 3'h1,
        MODE_STANDBY = 3'h3,
        MODE_NORMAL  = 3'h2,
        MODE_SLEEP   = 3'h6,
        MODE_WAKE    = 3'h7
    } mode_t;

    // Pins and flags arriving from outside the clock domain
    typedef struct packed {
        logic txd;
        logic sleep_request_n;
        logic role_select;
        logic clk_pin;
        logic bus_rx;
        logic lvr;
        logic tsd;
        logic wake_evt;
    } pin_in_t;

    localparam pin_in_t PIN_RESET = '{txd: 1'b1, sleep_request_n: 1'b1,
        role_select: 1'b0, clk_pin: 1'b1, bus_rx: 1'b1, lvr: 1'b1,
        tsd: 1'b0, wake_evt: 1'b0};

    // Status flags shown to the host side
    typedef struct packed {
        logic bus_error;
        logic arb_lost;
        logic tx_enabled;
        logic secondary_master;
        logic wake_retx;
    } status_t;
endpackage
`default_nettype wire

// File: verilog/pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins
`default_nettype none
`timescale 1ns/1ps
module pin_sync #(
    parameter int                  WIDTH     = 8,
    parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    // Raw pins
    input  wire logic [WIDTH-1:0] async_i,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] prev;

    // Synchroniser chain plus history stage
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta  <= RESET_VAL;
            stage <= RESET_VAL;
            prev  <= RESET_VAL;
        end else begin
            meta  <= async_i;
            stage <= meta;
            prev  <= stage;
        end
    end

    // Edges from the settled stages only
    assign level_o = stage;
    assign rise_o  = stage & ~prev;
    assign fall_o  = ~stage & prev;
endmodule // pin_sync
`default_nettype wire

// File: sim/cxpi_chk.sv
// Port assertions for the role switch and txd guard block
`default_nettype none
`timescale 1ns/1ps
module cxpi_chk #(
    parameter int WAKE_PULSE_CYC = 50
) (
    // Clock, reset and watched ports
    input wire logic                    clock_i,
    input wire logic                    nrst_i,
    input wire logic                    clk_pin_i,
    input wire logic                    clk_pin_oe_o,
    input wire logic                    rxd_o,
    input wire logic                    bus_rx_i,
    input wire logic                    bus_dom_o,
    input wire logic                    bus_en_o,
    input wire cxpi_guard_pkg::mode_t   mode_o,
    input wire cxpi_guard_pkg::status_t status_o
);
    logic        clk_q;
    logic [7:0]  n_rise;
    logic [15:0] n_wake;
    wire logic   nrm = mode_o == cxpi_guard_pkg::MODE_NORMAL;
    wire logic   pwr = mode_o == cxpi_guard_pkg::MODE_PWRUP;
    wire logic   wak = mode_o == cxpi_guard_pkg::MODE_WAKE;

    // Raw clock pin rises during power-up
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_q  <= 1'b1;
            n_rise <= 8'h00;
        end else begin
            clk_q  <= clk_pin_i;
            if (!pwr) n_rise <= 8'h00;
            else if (clk_pin_i && !clk_q) n_rise <= n_rise + 8'h01;
        end
    end

    // Cycles spent in the wake pulse
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) n_wake <= 16'h0000;
        else n_wake <= wak ? n_wake + 16'h0001 : 16'h0000;
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_resend;
        ##[0:3] wak;
    endsequence

    a_pwrup_count: assert property (
        $fell(pwr) |-> n_rise inside {[8'd32:8'd34]})
        else $error("power-up left at wrong clock count");
    a_pwrup_quiet: assert property (
        pwr && $past(pwr) |-> !bus_en_o && !bus_dom_o)
        else $error("bus driven during power-up");
    a_wake_drive: assert property (
        wak && $past(wak) |-> bus_dom_o)
        else $error("wake pulse not driven");
    a_wake_len: assert property (
        wak |-> n_wake < WAKE_PULSE_CYC)
        else $error("wake pulse too long");
    a_resend_wake: assert property (
        status_o.wake_retx |-> s_resend)
        else $error("resend without wake pulse");
    a_dom_guarded: assert property (
        nrm && $past(nrm) && bus_dom_o
        |-> status_o.tx_enabled || $past(status_o.tx_enabled))
        else $error("bus driven with guard closed");
    a_entry_rearm: assert property (
        nrm && !$past(nrm) |-> ##[0:1] !status_o.tx_enabled)
        else $error("guard not rearmed on normal entry");
    a_lost_quiet: assert property (
        nrm && $past(nrm) && status_o.arb_lost && $past(status_o.arb_lost)
        |-> !bus_dom_o)
        else $error("driving after lost arbitration");
    a_rx_follow: assert property (
        nrm && $past(nrm, 3) |-> rxd_o == $past(bus_rx_i, 3))
        else $error("receiver does not follow bus");
    a_sec_release: assert property (
        status_o.secondary_master && $past(status_o.secondary_master)
        |-> !clk_pin_oe_o)
        else $error("clock pin driven as stand-in master");
endmodule // cxpi_chk

bind cxpi_role_switch_arbitration_txd_guard cxpi_chk #(
    .WAKE_PULSE_CYC(WAKE_PULSE_CYC)
) u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .clk_pin_i(clk_pin_i),
    .clk_pin_oe_o(clk_pin_oe_o), .rxd_o(rxd_o), .bus_rx_i(bus_rx_i),
    .bus_dom_o(bus_dom_o), .bus_en_o(bus_en_o), .mode_o(mode_o),
    .status_o(status_o)
);
`default_nettype wire

// File: sim/cxpi_host.sv
// Host controller model on the pin side of the guard block
`default_nettype none
`timescale 1ns/1ps
module cxpi_host (
    // Clock
    input  wire logic clock_i,
    // Pins from the transceiver
    input  wire logic rxd_i,
    input  wire logic clk_in_i,
    // Pins to the transceiver
    output logic      txd_o,
    output logic      sleep_request_n_o,
    output logic      role_select_o,
    output logic      clk_o,
    output logic      clk_oe_o
);
    logic       run;
    logic [1:0] div;

    // Idle pins at time zero, txd stuck low
    initial begin
        txd_o = 1'b0;
        sleep_request_n_o = 1'b1;
        role_select_o = 1'b0;
        clk_oe_o = 1'b1;
        run = 1'b1;
        div = 2'h0;
        clk_o = 1'b1;
    end

    // Bit clock of 8 cycles, parked high when stopped
    always @(negedge clock_i) begin
        div <= div + 2'h1;
        if (!run) clk_o <= 1'b1;
        else if (div == 2'h3) clk_o <= !clk_o;
    end

    // Txd changes just after a bit clock fall while the clock runs
    task automatic set_txd(input logic v);
        if (run) @(negedge clk_o);
        else @(negedge clock_i);
        txd_o = v;
    endtask

    task automatic go_sleep;
        set_txd(1'b1);
        run = 1'b0;
        clk_oe_o = 1'b0;
        sleep_request_n_o = 1'b0;
    endtask

    // raise role select on idle receive
    task automatic to_slave;
        @(negedge clock_i);
        if (rxd_i) role_select_o = 1'b1;
    endtask

    // lower role select on high clock
    task automatic to_master;
        @(negedge clock_i);
        if (clk_in_i) role_select_o = 1'b0;
    endtask

    task automatic start(input logic drv);
        @(negedge clock_i);
        sleep_request_n_o = 1'b1;
        run = drv;
        clk_oe_o = drv;
    endtask
endmodule // cxpi_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the role switch and txd guard block
`default_nettype none
`timescale 1ns/1ps
module testbench;
    localparam int LOSS = 200;
    logic clock_i, nrst_i, lvr, tsd, wake, other;
    logic txd, slp_n, role, h_clk, h_oe, clk_o, clk_oe, rxd, rxd_oe;
    logic bus_dom, bus_en;
    wire logic clk_pin;
    wire logic bus_rx;
    cxpi_guard_pkg::mode_t   mode;
    cxpi_guard_pkg::status_t st;
    int n_fail;
    int checks_done;

    // Pulled-up clock pin and wired bus
    assign clk_pin = clk_oe ? clk_o : (h_oe ? h_clk : 1'b1);
    assign bus_rx = !(bus_dom & bus_en) & other;

    cxpi_role_switch_arbitration_txd_guard #(
        .CLK_LOSS_CYC(LOSS), .WAKE_PULSE_CYC(50), .MODE_CHG_CYC(20)
    ) uut (
        .clock_i(clock_i), .nrst_i(nrst_i), .txd_i(txd),
        .sleep_request_n_i(slp_n), .role_select_i(role),
        .clk_pin_i(clk_pin), .clk_pin_o(clk_o), .clk_pin_oe_o(clk_oe),
        .rxd_o(rxd), .rxd_oe_o(rxd_oe), .bus_rx_i(bus_rx),
        .bus_dom_o(bus_dom), .bus_en_o(bus_en), .lvr_i(lvr), .tsd_i(tsd),
        .wake_evt_i(wake), .mode_o(mode), .status_o(st)
    );

    cxpi_host host (
        .clock_i(clock_i), .rxd_i(rxd), .clk_in_i(clk_pin), .txd_o(txd),
        .sleep_request_n_o(slp_n), .role_select_o(role), .clk_o(h_clk),
        .clk_oe_o(h_oe)
    );

    task automatic test_done;
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic wait_mode(input cxpi_guard_pkg::mode_t m, input int n);
        int i;
        for (i = 0; i < n && mode !== m; i++) @(negedge clock_i);
        chk(mode === m, 1'b1, "mode");
    endtask

    // Power-up counts bit clocks before enabling the bus
    task automatic t_powerup;
        lvr = 1'b0;
        wait_mode(cxpi_guard_pkg::MODE_PWRUP, 10);
        cyc(30 * 8);
        chk(bus_en, 1'b0, "bus enabled early");
        wait_mode(cxpi_guard_pkg::MODE_STANDBY, 40);
        cyc(2);
        chk(bus_en, 1'b1, "bus not enabled");
        chk(bus_dom, 1'b0, "bus not high");
        wait_mode(cxpi_guard_pkg::MODE_NORMAL, 40);
    endtask

    // Stuck-low txd keeps bus free, receiver alive
    task automatic t_stuck;
        cyc(10);
        chk(st.tx_enabled, 1'b0, "tx enabled");
        chk(bus_dom, 1'b0, "bus held low");
        other = 1'b0;
        cyc(5);
        chk(rxd, 1'b0, "receiver idle");
        other = 1'b1;
    endtask

    // High then falling txd opens the path
    task automatic t_toggle;
        host.set_txd(1'b1);
        cyc(5);
        host.set_txd(1'b0);
        cyc(8);
        chk(st.tx_enabled, 1'b1, "toggle ignored");
        chk(bus_dom, 1'b1, "data not sent");
        chk(rxd, 1'b0, "no readback");
        host.set_txd(1'b1);
    endtask

    // Recessive bit overwritten by another node
    task automatic t_arb;
        cyc(2);
        other = 1'b0;
        cyc(10);
        chk(st.arb_lost, 1'b1, "no loss");
        host.set_txd(1'b0);
        cyc(4);
        chk(bus_dom, 1'b0, "sent after loss");
        chk(rxd, 1'b0, "receiver lost");
        other = 1'b1;
        host.set_txd(1'b1);
        cyc(12 * 8);
        chk(st.arb_lost, 1'b0, "loss kept");
    endtask

    // Silent bus raises the error until an edge
    task automatic t_buserr;
        cyc(LOSS + 10);
        chk(st.bus_error, 1'b1, "no bus error");
        other = 1'b0;
        cyc(2);
        other = 1'b1;
        cyc(5);
        chk(st.bus_error, 1'b0, "bus error kept");
    endtask

    // Thermal stop closes the guard until a toggle
    task automatic t_tsd;
        tsd = 1'b1;
        cyc(4);
        chk(bus_en, 1'b0, "driver kept on");
        tsd = 1'b0;
        cyc(6);
        chk(st.tx_enabled, 1'b0, "guard open");
        host.set_txd(1'b0);
        cyc(5);
        chk(st.tx_enabled, 1'b1, "toggle ignored");
        host.set_txd(1'b1);
    endtask

    // Sleep, local wake pulse, then resend without clock
    task automatic t_sleep;
        int i;
        host.go_sleep;
        wait_mode(cxpi_guard_pkg::MODE_SLEEP, 10);
        wake = 1'b1;
        cyc(4);
        wake = 1'b0;
        wait_mode(cxpi_guard_pkg::MODE_WAKE, 5);
        cyc(2);
        chk(bus_dom, 1'b1, "no wake pulse");
        wait_mode(cxpi_guard_pkg::MODE_SLEEP, 60);
        for (i = 0; i < 300 && st.wake_retx !== 1'b1; i++) cyc(1);
        chk(st.wake_retx, 1'b1, "no resend");
    endtask

    // Master to slave, then stand-in clock master
    task automatic t_role;
        wait_mode(cxpi_guard_pkg::MODE_WAKE, 5);
        wait_mode(cxpi_guard_pkg::MODE_SLEEP, 80);
        cyc(5);
        chk(rxd, 1'b1, "bus busy");
        host.to_slave;
        cyc(5);
        host.start(1'b0);
        wait_mode(cxpi_guard_pkg::MODE_NORMAL, 200);
        cyc(3);
        chk(clk_oe, 1'b1, "slave clock off");
        cyc(LOSS + 20);
        chk(st.secondary_master, 1'b1, "no stand-in");
        chk(clk_oe, 1'b0, "clock pin driven");
        host.go_sleep;
        wait_mode(cxpi_guard_pkg::MODE_SLEEP, 10);
        host.to_master;
    endtask

    // Clock generator
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Watchdog
    initial begin
        #150000;
        n_fail++;
        test_done;
    end

    // Main sequence
    initial begin
        nrst_i = 1'b0;
        lvr = 1'b1;
        tsd = 1'b0;
        wake = 1'b0;
        other = 1'b1;
        n_fail = 0;
        checks_done = 0;
        cyc(5);
        nrst_i = 1'b1;
        cyc(2);
        t_powerup;
        t_stuck;
        t_toggle;
        t_arb;
        t_buserr;
        t_tsd;
        t_sleep;
        t_role;
        test_done;
    end
endmodule // testbench
`default_nettype wire
